//--- ucl_defs.vh
// Purpose: constants shared by the unified cache test and lock logic
// Assumes: included by bare name from the design files
// Notes:   definitions only
`ifndef UCL_DEFS_VH
`define UCL_DEFS_VH

// ****************************************************************
// register indices
// ****************************************************************
`define UCL_IDX_DATA     8'h03
`define UCL_IDX_ADDR     8'h04
`define UCL_IDX_CTRL     8'h05

// ****************************************************************
// test_ctrl_reg fields
// ****************************************************************
`define UCL_MGMT_BIT     23
`define UCL_STATE_HI     19
`define UCL_STATE_LO     16
`define UCL_REC_HI       11
`define UCL_REC_LO       8
`define UCL_SET_HI       5
`define UCL_SET_LO       4
`define UCL_OP_HI        2
`define UCL_OP_LO        1
`define UCL_CTRL_RST     32'h00000000
`define UCL_ADDR_RST     32'h00000000
`define UCL_DATA_RST     32'h00000000
`define UCL_ADDR_MASK    32'hFFFFFFFC

// ****************************************************************
// address split
// ****************************************************************
`define UCL_TAG_HI       31
`define UCL_TAG_LO       14
`define UCL_LINE_HI      13
`define UCL_LINE_LO      5
`define UCL_WORD_HI      4
`define UCL_WORD_LO      2
`define UCL_TAG_W        19
`define UCL_LINE_W       9
`define UCL_LINES        512
`define UCL_LAST_LINE    9'h1FF
`define UCL_LINE_ZERO    9'h000
`define UCL_SETS         4
`define UCL_WORDS_ALL    16384

// ****************************************************************
// op_field codes
// ****************************************************************
`define UCL_OP_FLUSH     2'h0
`define UCL_OP_WRITE     2'h1
`define UCL_OP_READ      2'h2
`define UCL_OP_NOP       2'h3

// ****************************************************************
// state_field codes
// ****************************************************************
`define UCL_ST_MOD       4'h8
`define UCL_ST_SHR       4'h9
`define UCL_ST_EXC       4'hA
`define UCL_ST_INV       4'h3
`define UCL_ST_LKV       4'hC
`define UCL_ST_LKI       4'h7
`define UCL_ST_SHR_BIT   0

// ****************************************************************
// sweep modes
// ****************************************************************
`define UCL_SW_CLEAR     2'h0
`define UCL_SW_INVAL     2'h1
`define UCL_SW_DOWN      2'h2

`endif

//--- ucl_set_bank.v
// Purpose: tag and state store of one cache set, with a sweep port
// Assumes: sweep and single writes never fall in the same cycle
// Notes:   combinational read, clocked write
`timescale 1ns/1ps
`include "ucl_defs.vh"

module ucl_set_bank (
  core_clk,
  wrEn,
  wrIdx,
  wrTag,
  wrState,
  sweepEn,
  sweepMode,
  sweepIdx,
  rdIdx,
  rdTag,
  rdState
);
  input  wire                     core_clk;
  input  wire                     wrEn;
  input  wire [`UCL_LINE_W-1:0]   wrIdx;
  input  wire [`UCL_TAG_W-1:0]    wrTag;
  input  wire [3:0]               wrState;
  input  wire                     sweepEn;
  input  wire [1:0]               sweepMode;
  input  wire [`UCL_LINE_W-1:0]   sweepIdx;
  input  wire [`UCL_LINE_W-1:0]   rdIdx;
  output wire [`UCL_TAG_W-1:0]    rdTag;
  output wire [3:0]               rdState;

  reg [`UCL_TAG_W-1:0] tagMem   [0:`UCL_LINES-1];
  reg [3:0]            stateMem [0:`UCL_LINES-1];

  // ****************************************************************
  // sweep transform
  // ****************************************************************
  function [3:0] sweepNext;
    input [1:0] mode;
    input [3:0] st;
    begin
      sweepNext = st;
      case (mode)
        `UCL_SW_CLEAR: sweepNext = `UCL_ST_INV; // RQ22
        `UCL_SW_INVAL: begin
          // locked lines survive every non power-on invalidate
          if (st != `UCL_ST_LKV && st != `UCL_ST_LKI) begin // RQ22 RQ19
            sweepNext = `UCL_ST_INV;
          end
        end
        `UCL_SW_DOWN: begin
          if (st == `UCL_ST_MOD) begin // RQ14
            sweepNext = st | (4'h1 << `UCL_ST_SHR_BIT);
          end
        end
        default: sweepNext = st;
      endcase
    end
  endfunction

  assign rdTag   = tagMem[rdIdx];
  assign rdState = stateMem[rdIdx];

  always @(posedge core_clk) begin
    if (sweepEn) begin
      stateMem[sweepIdx] <= sweepNext(sweepMode, stateMem[sweepIdx]);
    end else if (wrEn) begin
      tagMem[wrIdx]   <= wrTag; // RQ1 RQ12
      stateMem[wrIdx] <= wrState; // RQ18
    end
  end

endmodule // ucl_set_bank

//--- ucl_cache_test.v
// Purpose: test register access and line locking for a four-set cache
// Assumes: requests come from same-clock core logic; pins are synced
// Notes:   power-on clear sweep runs after rst; busy covers every sweep
//
// Operation
// [RQ1] a written line keeps address bits 31..14 as its tag
// [RQ2] bits 13..5 pick the line, bits 4..2 the word
// [RQ3] set_select bits 5..4 choose the set a test acts on
// [RQ4] a test operation starts only on a test_ctrl_reg write
// [RQ5] op 00 flush, 01 write, 10 read, 11 nothing changes
// [RQ6] software loads address and data before a write op
// [RQ7] software needs eight word accesses for a full line
// [RQ8] state_field bits 19..16 hold the six line state codes
// [RQ9] recency_field bits 11..8 hold least-recently-used information
// [RQ10] bit 23 selects the separate management space; the bit is only stored in the tag and the core lookup ignores it
// [RQ11] address register holds bits 31..2, data register full word
// [RQ12] test write stores data word and tag at selected place
// [RQ13] test read loads state, recency and data into registers
// [RQ14] flush walks all lines, modified become shared
// [RQ15] software fills a whole line before marking it valid
// [RQ16] index 03h reaches data register, 04h address register
// [RQ17] index 05h write runs op, read returns control register
// [RQ18] a line is locked singly by the locked-valid state
// [RQ19] locked lines stay accessible and are never kept coherent
// [RQ20] software always leaves one set unlocked
// [RQ21] software never locks the same address twice
// [RQ22] power-on clears locks; warm reset and invalidates keep them
// [RQ23] an op completes before the next register access is taken
`timescale 1ns/1ps
`include "ucl_defs.vh"

module ucl_cache_test (
  core_clk,
  rst,
  regWr,
  regRd,
  regIdx,
  regWdata,
  regRdata,
  regAck,
  busy,
  warmRst,
  flushPin_n,
  invalidateInsn,
  writebackInvalidateInsn,
  coreReq,
  coreWe,
  coreAddr,
  coreWdata,
  coreRdata,
  coreHit,
  coreAck
);
  input  wire        core_clk;
  input  wire        rst;
  input  wire        regWr;
  input  wire        regRd;
  input  wire [7:0]  regIdx;
  input  wire [31:0] regWdata;
  output reg  [31:0] regRdata;
  output reg         regAck;
  output reg         busy;
  input  wire        warmRst;
  input  wire        flushPin_n;
  input  wire        invalidateInsn;
  input  wire        writebackInvalidateInsn;
  input  wire        coreReq;
  input  wire        coreWe;
  input  wire [31:0] coreAddr;
  input  wire [31:0] coreWdata;
  output reg  [31:0] coreRdata;
  output reg         coreHit;
  output reg         coreAck;

  localparam [3:0] S_CLEAR = 4'h1;
  localparam [3:0] S_IDLE  = 4'h2;
  localparam [3:0] S_DOWN  = 4'h4;
  localparam [3:0] S_INVAL = 4'h8;

  reg [31:0]             ctrl_q;
  reg [31:0]             ctrl_d;
  reg [31:0]             addr_q;
  reg [31:0]             addr_d;
  reg [31:0]             data_q;
  reg [31:0]             data_d;
  reg [3:0]              fsm_q;
  reg [3:0]              fsm_d;
  reg [`UCL_LINE_W-1:0]  sweep_q;
  reg [`UCL_LINE_W-1:0]  sweep_d;
  reg                    pend_q;
  reg                    pend_d;
  reg                    flushS1_q;
  reg                    flushS2_q;
  reg                    flushS3_q;
  reg                    warmS1_q;
  reg                    warmS2_q;
  reg                    warmS3_q;
  reg [31:0]             rdata_d;
  reg                    ack_d;
  reg                    tWr;
  reg [1:0]              sweepMode;
  reg                    sweepEn;

  reg [31:0] dataMem [0:`UCL_WORDS_ALL-1];
  reg [3:0]  recMem  [0:`UCL_LINES-1];

  wire [4*`UCL_TAG_W-1:0] tagBus;
  wire [15:0]             stateBus;
  wire [3:0]              hitVec;

  // ****************************************************************
  // helpers
  // ****************************************************************
  function isValid;
    input [3:0] st;
    begin
      isValid = (st == `UCL_ST_MOD) | (st == `UCL_ST_SHR) |
                (st == `UCL_ST_EXC) | (st == `UCL_ST_LKV);
    end
  endfunction

  function [1:0] firstSet;
    input [3:0] v;
    begin
      firstSet = 2'h0;
      if (v[3]) firstSet = 2'h3;
      if (v[2]) firstSet = 2'h2;
      if (v[1]) firstSet = 2'h1;
      if (v[0]) firstSet = 2'h0;
    end
  endfunction

  function [13:0] wordIdx;
    input [1:0]  set;
    input [31:0] a;
    begin
      wordIdx = {set, a[`UCL_LINE_HI:`UCL_LINE_LO],
                 a[`UCL_WORD_HI:`UCL_WORD_LO]}; // RQ2
    end
  endfunction

  // ****************************************************************
  // request decode
  // ****************************************************************
  wire        idle      = fsm_q[1];
  wire        regReq    = regWr | regRd;
  wire        regTake   = regReq & idle & ~pend_q & ~busy; // RQ23
  wire        coreTake  = coreReq & idle & ~pend_q & ~busy & ~regReq;
  wire        ctrlWr    = regTake & regWr & (regIdx == `UCL_IDX_CTRL);
  wire [1:0]  newOp     = regWdata[`UCL_OP_HI:`UCL_OP_LO];
  wire [1:0]  selSet    = regWdata[`UCL_SET_HI:`UCL_SET_LO]; // RQ3
  wire [31:0] lookAddr  = coreTake ? coreAddr : addr_q;
  wire [`UCL_LINE_W-1:0] rdLine = lookAddr[`UCL_LINE_HI:`UCL_LINE_LO];
  wire [`UCL_TAG_W-1:0]  tWrTag =
    {regWdata[`UCL_MGMT_BIT], addr_q[`UCL_TAG_HI:`UCL_TAG_LO]}; // RQ1 RQ10
  wire [`UCL_TAG_W-1:0]  selTag =
    tagBus[selSet*`UCL_TAG_W +: `UCL_TAG_W];
  wire [3:0]  selState  = stateBus[selSet*4 +: 4];
  wire [1:0]  hitSet    = firstSet(hitVec);
  wire        invEvent  = (~flushS2_q & flushS3_q) | (warmS2_q & ~warmS3_q) |
                          invalidateInsn | writebackInvalidateInsn;

  // ****************************************************************
  // set banks
  // ****************************************************************
  genvar g;
  generate
    for (g = 0; g < `UCL_SETS; g = g + 1) begin : gBank
      wire [`UCL_TAG_W-1:0] bTag;
      wire [3:0]            bState;
      ucl_set_bank uBank (
        .core_clk  (core_clk),
        .wrEn      (tWr & (selSet == g)), // RQ3 RQ12
        .wrIdx     (addr_q[`UCL_LINE_HI:`UCL_LINE_LO]),
        .wrTag     (tWrTag),
        .wrState   (regWdata[`UCL_STATE_HI:`UCL_STATE_LO]), // RQ8
        .sweepEn   (sweepEn),
        .sweepMode (sweepMode),
        .sweepIdx  (sweep_q),
        .rdIdx     (rdLine),
        .rdTag     (bTag),
        .rdState   (bState)
      );
      assign tagBus[g*`UCL_TAG_W +: `UCL_TAG_W] = bTag;
      assign stateBus[g*4 +: 4]                 = bState;
      // core lookup ignores the management space bit of the tag
      assign hitVec[g] = isValid(bState) &
        (bTag[`UCL_TAG_W-2:0] == coreAddr[`UCL_TAG_HI:`UCL_TAG_LO]);
    end
  endgenerate

  // ****************************************************************
  // control
  // ****************************************************************
  always @* begin
    fsm_d     = fsm_q;
    sweep_d   = sweep_q;
    ctrl_d    = ctrl_q;
    addr_d    = addr_q;
    data_d    = data_q;
    rdata_d   = regRdata;
    ack_d     = 1'b0;
    tWr       = 1'b0;
    sweepEn   = 1'b0;
    sweepMode = `UCL_SW_CLEAR;
    pend_d    = (pend_q & ~(idle & pend_q)) | invEvent;
    case (fsm_q)
      S_CLEAR: begin
        sweepEn   = 1'b1;
        sweepMode = `UCL_SW_CLEAR; // RQ22
        sweep_d   = sweep_q + 1'b1;
        if (sweep_q == `UCL_LAST_LINE) begin
          fsm_d = S_IDLE;
        end
      end
      S_DOWN: begin
        sweepEn   = 1'b1;
        sweepMode = `UCL_SW_DOWN; // RQ14
        sweep_d   = sweep_q + 1'b1;
        if (sweep_q == `UCL_LAST_LINE) begin
          fsm_d = S_IDLE;
          ack_d = 1'b1; // RQ23
        end
      end
      S_INVAL: begin
        sweepEn   = 1'b1;
        sweepMode = `UCL_SW_INVAL; // RQ22
        sweep_d   = sweep_q + 1'b1;
        if (sweep_q == `UCL_LAST_LINE) begin
          fsm_d = S_IDLE;
        end
      end
      S_IDLE: begin
        sweep_d = `UCL_LINE_ZERO;
        if (pend_q) begin
          fsm_d = S_INVAL;
        end else if (regTake) begin
          ack_d = ~ctrlWr | (newOp != `UCL_OP_FLUSH);
          if (regRd) begin
            case (regIdx)
              `UCL_IDX_DATA: rdata_d = data_q; // RQ16
              `UCL_IDX_ADDR: rdata_d = addr_q; // RQ16
              `UCL_IDX_CTRL: rdata_d = ctrl_q; // RQ17
              default:       rdata_d = 32'h00000000;
            endcase
          end else begin
            case (regIdx)
              `UCL_IDX_DATA: data_d = regWdata; // RQ11 RQ16
              `UCL_IDX_ADDR: addr_d = regWdata & `UCL_ADDR_MASK; // RQ11
              `UCL_IDX_CTRL: begin
                case (newOp) // RQ4 RQ5 RQ17
                  `UCL_OP_FLUSH: begin
                    ctrl_d = regWdata;
                    fsm_d  = S_DOWN; // RQ14
                  end
                  `UCL_OP_WRITE: begin
                    ctrl_d = regWdata;
                    tWr    = 1'b1; // RQ12
                  end
                  `UCL_OP_READ: begin
                    ctrl_d = regWdata; // RQ13
                    ctrl_d[`UCL_STATE_HI:`UCL_STATE_LO] = selState;
                    ctrl_d[`UCL_REC_HI:`UCL_REC_LO] =
                      recMem[addr_q[`UCL_LINE_HI:`UCL_LINE_LO]]; // RQ9
                    ctrl_d[`UCL_MGMT_BIT] = selTag[`UCL_TAG_W-1];
                    data_d = dataMem[wordIdx(selSet, addr_q)];
                  end
                  `UCL_OP_NOP: ctrl_d = ctrl_q; // RQ5
                  default:     ctrl_d = ctrl_q;
                endcase
              end
              default: data_d = data_q;
            endcase
          end
        end
      end
      default: fsm_d = S_CLEAR;
    endcase
  end

  // ****************************************************************
  // arrays
  // ****************************************************************
  always @(posedge core_clk) begin
    if (tWr) begin
      dataMem[wordIdx(selSet, addr_q)] <= data_q; // RQ12
      recMem[addr_q[`UCL_LINE_HI:`UCL_LINE_LO]] <=
        regWdata[`UCL_REC_HI:`UCL_REC_LO]; // RQ9
    end else if (coreTake & coreWe & (|hitVec)) begin
      dataMem[wordIdx(hitSet, coreAddr)] <= coreWdata; // RQ19
    end
  end

  // ****************************************************************
  // registers
  // ****************************************************************
  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      fsm_q     <= S_CLEAR;
      sweep_q   <= `UCL_LINE_ZERO;
      ctrl_q    <= `UCL_CTRL_RST;
      addr_q    <= `UCL_ADDR_RST;
      data_q    <= `UCL_DATA_RST;
      pend_q    <= 1'b0;
      flushS1_q <= 1'b1;
      flushS2_q <= 1'b1;
      flushS3_q <= 1'b1;
      warmS1_q  <= 1'b0;
      warmS2_q  <= 1'b0;
      warmS3_q  <= 1'b0;
      regRdata  <= 32'h00000000;
      regAck    <= 1'b0;
      busy      <= 1'b1;
      coreRdata <= 32'h00000000;
      coreHit   <= 1'b0;
      coreAck   <= 1'b0;
    end else begin
      fsm_q     <= fsm_d;
      sweep_q   <= sweep_d;
      ctrl_q    <= ctrl_d;
      addr_q    <= addr_d;
      data_q    <= data_d;
      pend_q    <= pend_d;
      flushS1_q <= flushPin_n;
      flushS2_q <= flushS1_q;
      flushS3_q <= flushS2_q;
      warmS1_q  <= warmRst;
      warmS2_q  <= warmS1_q;
      warmS3_q  <= warmS2_q;
      regRdata  <= rdata_d;
      regAck    <= ack_d;
      busy      <= ~fsm_d[1] | pend_d | ctrlWr; // RQ23
      coreAck   <= coreTake;
      coreHit   <= coreTake & (|hitVec);
      if (coreTake) begin
        coreRdata <= dataMem[wordIdx(hitSet, coreAddr)]; // RQ19
      end
    end
  end

endmodule // ucl_cache_test

//--- ucl_cache_test_properties.sv
// Purpose: port-level properties of the cache test and lock block
// Assumes: bound to ucl_cache_test; one clock domain
// Notes:   quiet masks the cycles near invalidate triggers and pin sync
`timescale 1ns/1ps
`include "ucl_defs.vh"

module ucl_cache_test_properties (
  input wire        core_clk,
  input wire        rst,
  input wire        regWr,
  input wire        regRd,
  input wire [7:0]  regIdx,
  input wire [31:0] regWdata,
  input wire [31:0] regRdata,
  input wire        regAck,
  input wire        busy,
  input wire        warmRst,
  input wire        flushPin_n,
  input wire        invalidateInsn,
  input wire        writebackInvalidateInsn,
  input wire        coreReq,
  input wire        coreAck
);
  // ****************************************************************
  // helper logic
  // ****************************************************************
  reg  [2:0] quietCnt_q;
  wire       trig;
  wire       quiet;
  wire       ctrlWr;
  wire       isFlush;
  assign trig    = invalidateInsn | writebackInvalidateInsn
                 | warmRst | ~flushPin_n;
  assign quiet   = (quietCnt_q == 3'h7);
  assign ctrlWr  = quiet && !busy && regWr && (regIdx == `UCL_IDX_CTRL);
  assign isFlush = (regWdata[2:1] == `UCL_OP_FLUSH);
  always @(posedge core_clk or posedge rst) begin
    if (rst)
      quietCnt_q <= 3'h0;
    else if (trig)
      quietCnt_q <= 3'h0;
    else if (quietCnt_q != 3'h7)
      quietCnt_q <= quietCnt_q + 3'h1;
  end
  // ****************************************************************
  // properties
  // ****************************************************************
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (rst);
  reg_ack_a: assert property (
    quiet && !busy && (regWr ? regIdx != `UCL_IDX_CTRL : regRd)
    |=> regAck && !busy) else $error("register access not acked");
  ctrl_ack_a: assert property (
    ctrlWr && !isFlush |=> regAck && busy ##1 !busy)
    else $error("control write timing wrong");
  flush_busy_a: assert property (
    ctrlWr && isFlush |=> busy [*8]) else $error("flush not busy");
  flush_ack_a: assert property (
    ctrlWr && isFlush |-> ##[513:513] regAck)
    else $error("flush ack not after full sweep");
  unmapped_zero_a: assert property (
    quiet && !busy && regRd && !regWr
    && (regIdx < `UCL_IDX_DATA || regIdx > `UCL_IDX_CTRL)
    |=> regAck && regRdata == 32'h00000000)
    else $error("unmapped read not zero");
  core_ack_a: assert property (
    quiet && !busy && coreReq && !regWr && !regRd |=> coreAck)
    else $error("core access not acked");
  core_refuse_a: assert property (
    coreReq && (busy || regWr || regRd) |=> !coreAck)
    else $error("core access taken while refused");
  ack_cause_a: assert property (
    regAck && !$past(busy) |-> $past(regWr || regRd))
    else $error("register ack without request");
  core_cause_a: assert property (
    coreAck |-> $past(coreReq)) else $error("core ack without request");
  boot_busy_a: assert property (
    $past(rst) |-> busy) else $error("not busy after power-on");
endmodule // ucl_cache_test_properties

//--- tb_top.sv
// Purpose: self-checking bench for the cache test and lock block
// Assumes: inputs change on the rising edge, outputs read at falling
// Notes:   table rows cover register loads, hand-written cases follow
`timescale 1ns/1ps
`include "ucl_defs.vh"

module tb_top;
  localparam int LIMIT = 20000;
  reg         core_clk, rst, regWr, regRd, warmRst, flushPin_n;
  reg         invalidateInsn, writebackInvalidateInsn, coreReq, coreWe;
  reg  [7:0]  regIdx;
  reg  [31:0] regWdata, coreAddr, coreWdata, rd, dw;
  wire [31:0] regRdata, coreRdata;
  wire        regAck, busy, coreHit, coreAck;
  reg  [71:0] rows [0:5];
  reg  [4:0]  codes [0:5];
  reg         hit;
  integer     fails = 0;
  integer     compares = 0;
  integer     cycles = 0;
  integer     i;

  ucl_cache_test dut (
    .core_clk(core_clk), .rst(rst), .regWr(regWr), .regRd(regRd),
    .regIdx(regIdx), .regWdata(regWdata), .regRdata(regRdata),
    .regAck(regAck), .busy(busy), .warmRst(warmRst),
    .flushPin_n(flushPin_n), .invalidateInsn(invalidateInsn),
    .writebackInvalidateInsn(writebackInvalidateInsn),
    .coreReq(coreReq), .coreWe(coreWe), .coreAddr(coreAddr),
    .coreWdata(coreWdata), .coreRdata(coreRdata), .coreHit(coreHit),
    .coreAck(coreAck));

  // ****************************************************************
  // helpers
  // ****************************************************************
  task report_and_stop;
    begin
      if (fails == 0 && compares > 0)
        $display("bench passed");
      else
        $display("bench failed");
      $finish;
    end
  endtask

  task chk(input [31:0] got, input [31:0] exp);
    begin
      compares = compares + 1;
      if (got !== exp) begin
        fails = fails + 1;
        $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
    end
  endtask

  function [31:0] ctl(input m, input [3:0] st, input [3:0] rc,
                      input [1:0] s, input [1:0] op);
    ctl = {8'h00, m, 3'h0, st, 4'h0, rc, 2'h0, s, 1'b0, op, 1'b0};
  endfunction

  // one word access: core selects the processor port, else registers
  task acc(input core, input wr, input [7:0] idx, input [31:0] a,
           input [31:0] wd, output [31:0] rdv);
    integer n;
    begin
      n = 0;
      @(negedge core_clk);
      while (busy !== 1'b0 && n < 1000) begin
        @(negedge core_clk);
        n = n + 1;
      end
      @(posedge core_clk);
      regWr <= !core && wr;
      regRd <= !core && !wr;
      coreReq <= core;
      coreWe <= wr;
      regIdx <= idx;
      coreAddr <= a;
      regWdata <= wd;
      coreWdata <= wd;
      @(posedge core_clk);
      regWr <= 1'b0;
      regRd <= 1'b0;
      coreReq <= 1'b0;
      n = 0;
      @(negedge core_clk);
      while ((core ? coreAck : regAck) !== 1'b1 && n < 1000) begin
        @(negedge core_clk);
        n = n + 1;
      end
      chk({31'h0, core ? coreAck : regAck}, 32'h1);
      rdv = core ? coreRdata : regRdata;
      hit = coreHit;
    end
  endtask

  task wr_line(input [1:0] s, input [31:0] a, input [31:0] d,
               input [3:0] st, input [3:0] rc, input m);
    begin
      acc(1'b0, 1'b1, `UCL_IDX_ADDR, 32'h0, a, rd);
      acc(1'b0, 1'b1, `UCL_IDX_DATA, 32'h0, d, rd);
      acc(1'b0, 1'b1, `UCL_IDX_CTRL, 32'h0, ctl(m, st, rc, s,
          `UCL_OP_WRITE), rd);
    end
  endtask

  task rd_line(input [1:0] s, input [31:0] a);
    begin
      acc(1'b0, 1'b1, `UCL_IDX_ADDR, 32'h0, a, rd);
      acc(1'b0, 1'b1, `UCL_IDX_CTRL, 32'h0, ctl(1'b0, 4'h0, 4'h0, s,
          `UCL_OP_READ), rd);
      acc(1'b0, 1'b0, `UCL_IDX_CTRL, 32'h0, 32'h0, rd);
      acc(1'b0, 1'b0, `UCL_IDX_DATA, 32'h0, 32'h0, dw);
    end
  endtask

  // ****************************************************************
  // clock, timeout, sequence
  // ****************************************************************
  initial begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end

  always @(posedge core_clk) begin
    cycles <= cycles + 1;
    if (cycles == LIMIT) begin
      fails = fails + 1;
      report_and_stop;
    end
  end

  initial begin
    {rst, flushPin_n} = 2'h3;
    {regWr, regRd, warmRst, invalidateInsn} = 4'h0;
    {writebackInvalidateInsn, coreReq, coreWe} = 3'h0;
    {regIdx, regWdata, coreAddr, coreWdata} = 104'h0;
    rows[0] = {8'h05, 32'hFFFFFFFF, 32'h00000000};
    rows[1] = {8'h03, 32'hA5A55A5A, 32'hA5A55A5A};
    rows[2] = {8'h04, 32'h12345677, 32'h12345674};
    rows[3] = {8'h04, 32'hFFFFFFFF, 32'hFFFFFFFC};
    rows[4] = {8'h07, 32'hDEADBEEF, 32'h00000000};
    rows[5] = {8'hFF, 32'h0F0F0F0F, 32'h00000000};
    codes[0] = 5'h18;
    codes[1] = 5'h19;
    codes[2] = 5'h1A;
    codes[3] = 5'h03;
    codes[4] = 5'h1C;
    codes[5] = 5'h07;
    repeat (5) @(posedge core_clk);
    rst <= 1'b0;
    @(posedge core_clk);
    coreReq <= 1'b1;
    @(posedge core_clk);
    coreReq <= 1'b0;
    @(negedge core_clk);
    chk({31'h0, coreAck}, 32'h0);
    for (i = 3; i < 6; i = i + 1) begin
      acc(1'b0, 1'b0, i[7:0], 32'h0, 32'h0, rd);
      chk(rd, 32'h0);
    end
    for (i = 0; i < 6; i = i + 1) begin
      acc(1'b0, 1'b1, rows[i][71:64], 32'h0, rows[i][63:32], rd);
      acc(1'b0, 1'b0, rows[i][71:64], 32'h0, 32'h0, rd);
      chk(rd, rows[i][31:0]);
    end
    for (i = 0; i < 4; i = i + 1)
      wr_line(i[1:0], 32'h000100A4 + 32'h00010000 * i, 32'hC0DE0000 + i,
              `UCL_ST_EXC, 4'h5, i[0]);
    for (i = 0; i < 4; i = i + 1) begin
      rd_line(i[1:0], 32'h000100A4 + 32'h00010000 * i);
      chk(rd, ctl(i[0], `UCL_ST_EXC, 4'h5, i[1:0], `UCL_OP_READ));
      chk(dw, 32'hC0DE0000 + i);
      acc(1'b1, 1'b0, 8'h00, 32'h000100A4 + 32'h00010000 * i, 32'h0, dw);
      chk({31'h0, hit}, 32'h1);
      chk(dw, 32'hC0DE0000 + i);
    end
    acc(1'b1, 1'b0, 8'h00, 32'h00F000A4, 32'h0, dw);
    chk({31'h0, hit}, 32'h0);
    for (i = 0; i < 8; i = i + 1)
      wr_line(2'h3, 32'h00030120 + 4 * i, 32'h51000000 + i, `UCL_ST_EXC,
              4'h1, 1'b0);
    for (i = 0; i < 8; i = i + 1) begin
      acc(1'b1, 1'b0, 8'h00, 32'h00030120 + 4 * i, 32'h0, dw);
      chk(dw, 32'h51000000 + i);
    end
    for (i = 0; i < 6; i = i + 1) begin
      wr_line(2'h0, 32'h00000180, 32'h77000000 + i, codes[i][3:0], 4'h3,
              i[0]);
      rd_line(2'h0, 32'h00000180);
      chk(rd, ctl(i[0], codes[i][3:0], 4'h3, 2'h0, `UCL_OP_READ));
      acc(1'b1, 1'b0, 8'h00, 32'h00000180, 32'h0, dw);
      chk({31'h0, hit}, {31'h0, codes[i][4]});
    end
    wr_line(2'h0, 32'h00010280, 32'h11111111, `UCL_ST_MOD, 4'h2, 1'b0);
    wr_line(2'h2, 32'h00030280, 32'h33333333, `UCL_ST_LKV, 4'h2,
            1'b0);
    acc(1'b1, 1'b1, 8'h00, 32'h00030280, 32'hBEEF0042, dw);
    acc(1'b1, 1'b0, 8'h00, 32'h00030280, 32'h0, dw);
    chk(dw, 32'hBEEF0042);
    wr_line(2'h1, 32'h00020280, 32'h22222222, `UCL_ST_EXC, 4'h2, 1'b0);
    acc(1'b0, 1'b1, `UCL_IDX_CTRL, 32'h0, 32'h00000000, rd);
    // shared, exclusive and locked valid expected after the sweep
    for (i = 0; i < 3; i = i + 1) begin
      rd_line(i[1:0], 32'h00010280 + 32'h00010000 * i);
      chk({28'h0, rd[19:16]}, {28'h0, codes[1 << i][3:0]});
    end
    for (i = 0; i < 4; i = i + 1) begin
      wr_line(2'h1, 32'h00020280, 32'h0, `UCL_ST_EXC, 4'h2, 1'b0);
      @(posedge core_clk);
      invalidateInsn <= (i == 0);
      writebackInvalidateInsn <= (i == 1);
      warmRst <= (i == 2);
      flushPin_n <= (i != 3);
      @(posedge core_clk);
      {invalidateInsn, writebackInvalidateInsn} <= 2'h0;
      repeat (2) @(posedge core_clk);
      {invalidateInsn, writebackInvalidateInsn, warmRst} <= 3'h0;
      flushPin_n <= 1'b1;
      repeat (4) @(posedge core_clk);
      rd_line(2'h2, 32'h00030280);
      chk({28'h0, rd[19:16]}, {28'h0, `UCL_ST_LKV});
      rd_line(2'h1, 32'h00020280);
      chk({28'h0, rd[19:16]}, {28'h0, `UCL_ST_INV});
    end
    @(posedge core_clk);
    rst <= 1'b1;
    repeat (5) @(posedge core_clk);
    rst <= 1'b0;
    rd_line(2'h2, 32'h00030280);
    chk({28'h0, rd[19:16]}, {28'h0, `UCL_ST_INV});
    report_and_stop;
  end
endmodule // tb_top

bind ucl_cache_test ucl_cache_test_properties props (
  .core_clk(core_clk), .rst(rst), .regWr(regWr), .regRd(regRd),
  .regIdx(regIdx), .regWdata(regWdata), .regRdata(regRdata),
  .regAck(regAck), .busy(busy), .warmRst(warmRst),
  .flushPin_n(flushPin_n), .invalidateInsn(invalidateInsn),
  .writebackInvalidateInsn(writebackInvalidateInsn),
  .coreReq(coreReq), .coreAck(coreAck));
